//--- src/fws_defs.vh
// constants for the flash write-status host controller
`ifndef FWS_DEFS_VH
`define FWS_DEFS_VH
// ============================================================
// register offsets (byte addresses, one word each)
`define FWS_REG_CTRL      8'h00
`define FWS_REG_ADDR      8'h04
`define FWS_REG_DATA      8'h08
`define FWS_REG_STATUS    8'h0c
`define FWS_REG_RDATA     8'h10
// ctrl fields
`define FWS_CTRL_GO       0
`define FWS_CTRL_WRITE    1
`define FWS_CTRL_POLL     2
`define FWS_CTRL_RESET    3
// status fields
`define FWS_ST_BUSY       0
`define FWS_ST_DONE       1
`define FWS_ST_FAIL       2
`define FWS_ST_RDY_PIN    3
`define FWS_ST_WINDOW     4
`define FWS_ST_SUSP       5
// data bit positions on the flash lanes
`define FWS_BIT_POLL      7
`define FWS_BIT_TOG1      6
`define FWS_BIT_TOUT      5
`define FWS_BIT_WIN       3
`define FWS_BIT_TOG2      2
// flash reset command data
`define FWS_CMD_RESET     8'hf0
// strobe timing: 100 ns clock, 200 ns strobe low and high
`define FWS_CLK_NS        100
`define FWS_STROBE_NS     200
`define FWS_STROBE_CYC    ((`FWS_STROBE_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`endif

//--- src/fws_cycle.v
// one asynchronous read or write cycle on the flash pins
`timescale 1ns/100ps
`default_nettype none
`include "fws_defs.vh"
module fws_cycle
(
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        clk_en,
  // request
  input  wire        start,
  input  wire        wr,
  input  wire [19:0] addr,
  input  wire [7:0]  wdata,
  output reg         done,
  output reg  [7:0]  rdata,
  // flash pins
  output reg  [19:0] flash_addr,
  output reg         chip_select_n,
  output reg         output_strobe_n,
  output reg         write_strobe_n,
  output reg  [7:0]  data_out,
  output reg         data_oe_n,
  input  wire [7:0]  data_in
);
  // ==========================================================
  // cycle timer
  localparam S_IDLE = 2'd0;
  localparam S_LOW  = 2'd1;
  localparam S_HIGH = 2'd2;
  reg [1:0] state;
  reg [3:0] cnt;
  // strobe low for the full width, then high gap; read data
  // latched before the strobe rises so it is stable
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= S_IDLE;
      cnt <= 4'h0;
      done <= 1'b0;
      rdata <= 8'h00;
      flash_addr <= 20'h00000;
      chip_select_n <= 1'b1;
      output_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
    end
    else if (clk_en)
    begin
      done <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (start)
          begin
            flash_addr <= addr;
            chip_select_n <= 1'b0;
            output_strobe_n <= wr;
            write_strobe_n <= ~wr;
            data_out <= wdata;
            data_oe_n <= ~wr;
            cnt <= 4'h0;
            state <= S_LOW;
          end
        end
        S_LOW:
        begin
          if (cnt == `FWS_STROBE_CYC - 1)
          begin
            // each rising edge of the read strobe completes one read cycle, so the
            // device's toggle bits advance once per call
            rdata <= data_in;
            chip_select_n <= 1'b1;
            output_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            cnt <= 4'h0;
            state <= S_HIGH;
          end
          else
            cnt <= cnt + 4'h1;
        end
        S_HIGH:
        begin
          data_oe_n <= 1'b1;
          if (cnt == `FWS_STROBE_CYC - 1)
          begin
            done <= 1'b1;
            state <= S_IDLE;
          end
          else
            cnt <= cnt + 4'h1;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- src/fws_host.v
// host controller: ahb-lite registers, flash access and toggle polling
// Function
// RQ1 - device pulls ready line low while busy
// RQ2 - device releases ready line when ready
// RQ3 - ready line is open drain, pull-up
// RQ4 - busy valid after last write strobe
// RQ5 - toggle one inverts per read while busy
// RQ6 - toggle one valid after last write
// RQ7 - all-protected erase toggles about 100 us
// RQ8 - protected program toggles about 1 us
// RQ9 - toggle one stops in erase suspend
// RQ10 - toggle two toggles in erasing sectors
// RQ11 - host reads twice, compares toggle bit
// RQ12 - toggling with timeout bit: recheck, reset
// RQ13 - resumed polling restarts with two reads
// RQ14 - timeout bit marks exceeded pulse limit
// RQ15 - programming one over zero fails
// RQ16 - host writes reset after timeout failure
// RQ17 - erase window bit 0 then 1
// RQ18 - host may skip window under 50 us
// RQ19 - window high ignores all but suspend
// RQ20 - host checks window around extra erase
// RQ21 - suspended sector read status pattern
// RQ22 - non-suspended sector read gives data
// RQ23 - host gives valid address for status
// RQ24 - polling bit inverse while programming
// RQ25 - polling bit zero while erasing
// RQ26 - toggle advances per completed read
//
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "fws_defs.vh"
module fws_host
(
  // clock, reset, enable
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        clk_en,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // flash pins
  output wire [19:0] flash_addr,
  output wire        chip_select_n,
  output wire        output_strobe_n,
  output wire        write_strobe_n,
  output wire [7:0]  data_out,
  output wire        data_oe_n,
  input  wire [7:0]  data_in,
  input  wire        ready_busy_n_in
);
  // ==========================================================
  // software-visible registers and the captured bus address phase
  reg [19:0] op_addr;
  reg [7:0]  op_data;
  reg [7:0]  rd_data;
  reg        busy;
  reg        done_flag;
  reg        fail_flag;
  reg        window_flag;
  reg        susp_flag;
  reg        rdy_pin;
  reg        ap_valid;
  reg        ap_write;
  reg [7:0]  ap_addr;
  // sequencer requests into the cycle engine
  reg        cyc_start;
  reg        cyc_wr;
  reg [7:0]  cyc_wdata;
  wire       cyc_done;
  wire [7:0] cyc_rdata;
  // ==========================================================
  // polling sequencer
  localparam P_IDLE  = 3'd0;
  localparam P_SINGL = 3'd1;
  localparam P_RD1   = 3'd2;
  localparam P_RD2   = 3'd3;
  localparam P_RD3   = 3'd4;
  localparam P_RST   = 3'd5;
  localparam P_WAIT  = 3'd6;
  reg [2:0] pstate;
  reg [7:0] first;
  wire      toggled = first[`FWS_BIT_TOG1] ^ cyc_rdata[`FWS_BIT_TOG1];
  wire      go = ap_valid && ap_write && ap_addr == `FWS_REG_CTRL &&
                 hwdata[`FWS_CTRL_GO] && !busy;
  // ready pin is sampled as a plain synchronous level
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rdy_pin <= 1'b1;
    else if (clk_en)
      rdy_pin <= ready_busy_n_in; // RQ1 RQ2 RQ3
  end
  // sequencer: single access, toggle poll, or reset command
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pstate <= P_IDLE;
      first <= 8'h00;
      busy <= 1'b0;
      done_flag <= 1'b0;
      fail_flag <= 1'b0;
      window_flag <= 1'b0;
      susp_flag <= 1'b0;
      rd_data <= 8'h00;
      cyc_start <= 1'b0;
      cyc_wr <= 1'b0;
      cyc_wdata <= 8'h00;
    end
    else if (clk_en)
    begin
      cyc_start <= 1'b0;
      case (pstate)
        P_IDLE:
        begin
          if (go)
          begin
            busy <= 1'b1;
            done_flag <= 1'b0;
            cyc_start <= 1'b1;
            if (hwdata[`FWS_CTRL_RESET])
            begin
              // RQ16
              cyc_wr <= 1'b1;
              cyc_wdata <= `FWS_CMD_RESET;
              pstate <= P_RST;
            end
            else if (hwdata[`FWS_CTRL_POLL])
            begin
              // a fresh poll always starts with two reads
              cyc_wr <= 1'b0; // RQ13 RQ23
              fail_flag <= 1'b0;
              pstate <= P_RD1;
            end
            else
            begin
              cyc_wr <= hwdata[`FWS_CTRL_WRITE];
              cyc_wdata <= op_data;
              pstate <= P_SINGL;
            end
          end
        end
        P_SINGL, P_RST:
        begin
          if (cyc_done)
          begin
            if (!cyc_wr)
              rd_data <= cyc_rdata;
            if (pstate == P_RST)
              fail_flag <= 1'b0;
            busy <= 1'b0;
            done_flag <= 1'b1;
            pstate <= P_IDLE;
          end
        end
        P_RD1:
        begin
          if (cyc_done)
          begin
            first <= cyc_rdata; // RQ11
            cyc_start <= 1'b1;
            pstate <= P_RD2;
          end
        end
        P_RD2, P_RD3:
        begin
          if (cyc_done)
          begin
            rd_data <= cyc_rdata;
            window_flag <= cyc_rdata[`FWS_BIT_WIN]; // RQ17 RQ19 RQ20 RQ18
            // toggle two toggling while toggle one stands: suspended
            susp_flag <= !toggled &&
                         (first[`FWS_BIT_TOG2] ^ cyc_rdata[`FWS_BIT_TOG2]);
            if (!toggled)
            begin
              // complete or suspended; next read returns array data outside a suspended sector
              busy <= 1'b0; // RQ11 RQ5 RQ26
              done_flag <= 1'b1;
              pstate <= P_IDLE;
            end
            else if (pstate == P_RD3)
            begin
              // still toggling after timeout seen: failed
              fail_flag <= 1'b1; // RQ12 RQ14 RQ15
              busy <= 1'b0;
              done_flag <= 1'b1;
              pstate <= P_IDLE;
            end
            else if (cyc_rdata[`FWS_BIT_TOUT])
            begin
              first <= cyc_rdata; // RQ12
              cyc_start <= 1'b1;
              pstate <= P_RD3;
            end
            else
            begin
              // keep polling: compare against the newest read
              first <= cyc_rdata;
              cyc_start <= 1'b1;
              pstate <= P_WAIT;
            end
          end
        end
        P_WAIT:
          pstate <= P_RD2;
        default:
          pstate <= P_IDLE;
      endcase
    end
  end
  // ==========================================================
  // ahb-lite slave, zero wait states
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
      op_addr <= 20'h00000;
      op_data <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (clk_en)
    begin
      ap_valid <= hsel && hready && htrans[1];
      ap_write <= hwrite;
      ap_addr <= haddr;
      if (ap_valid && ap_write && ap_addr == `FWS_REG_ADDR)
        op_addr <= hwdata[19:0];
      if (ap_valid && ap_write && ap_addr == `FWS_REG_DATA)
        op_data <= hwdata[7:0];
      // read data registered from the address phase
      hrdata <= 32'h00000000;
      if (hsel && hready && htrans[1] && !hwrite)
        case (haddr)
          `FWS_REG_ADDR:   hrdata <= {12'h000, op_addr};
          `FWS_REG_DATA:   hrdata <= {24'h000000, op_data};
          `FWS_REG_STATUS: hrdata <= {26'h0000000, susp_flag,
                                      window_flag, rdy_pin, fail_flag,
                                      done_flag, busy};
          `FWS_REG_RDATA:  hrdata <= {24'h000000, rd_data};
          default:         hrdata <= 32'h00000000;
        endcase
    end
  end
  // ==========================================================
  // pin cycle engine
  fws_cycle u_cycle
  (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .clk_en          (clk_en),
    .start           (cyc_start),
    .wr              (cyc_wr),
    .addr            (op_addr),
    .wdata           (cyc_wdata),
    .done            (cyc_done),
    .rdata           (cyc_rdata),
    .flash_addr      (flash_addr),
    .chip_select_n   (chip_select_n),
    .output_strobe_n (output_strobe_n),
    .write_strobe_n  (write_strobe_n),
    .data_out        (data_out),
    .data_oe_n       (data_oe_n),
    .data_in         (data_in)
  );
endmodule
`default_nettype wire

//--- tb/fws_host_chk.sv
// pin and bus checker bound to the flash host controller
`timescale 1ns/100ps
`default_nettype none
module fws_host_chk
(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus answer
  input wire logic        hreadyout,
  input wire logic        hresp,
  // flash pins
  input wire logic [19:0] flash_addr,
  input wire logic        chip_select_n,
  input wire logic        output_strobe_n,
  input wire logic        write_strobe_n,
  input wire logic [7:0]  data_out,
  input wire logic        data_oe_n
);
  // ============================================================
  // one domain, so one clock and one disable for all
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_no_wait: assert property (hreadyout && !hresp)
    else $error("bus slave waited or answered error");
  a_strobe_excl: assert property (output_strobe_n || write_strobe_n)
    else $error("read and write strobes low together");
  a_strobe_cs: assert property (!(output_strobe_n && write_strobe_n)
    |-> !chip_select_n) else $error("strobe without chip select");
  a_read_floats: assert property (!output_strobe_n |-> data_oe_n)
    else $error("host drives lanes during a read");
  a_write_drives: assert property (!write_strobe_n |-> !data_oe_n)
    else $error("write strobe without lane drive");
  a_read_width: assert property ($fell(output_strobe_n)
    |-> !output_strobe_n ##1 !output_strobe_n ##1 output_strobe_n)
    else $error("read strobe not two clocks low");
  a_addr_hold: assert property (!chip_select_n && !$past(chip_select_n)
    |-> $stable(flash_addr)) else $error("address moved in cycle");
  a_data_hold: assert property (!write_strobe_n && !$past(write_strobe_n)
    |-> $stable(data_out)) else $error("write data moved");
  // main traffic seen
  c_read: cover property ($fell(output_strobe_n));
  c_write: cover property ($fell(write_strobe_n));
  c_reset_cmd: cover property (!write_strobe_n && data_out == 8'hf0);
endmodule
bind fws_host fws_host_chk i_chk (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .flash_addr(flash_addr),
  .chip_select_n(chip_select_n), .output_strobe_n(output_strobe_n),
  .write_strobe_n(write_strobe_n), .data_out(data_out),
  .data_oe_n(data_oe_n));
`default_nettype wire

//--- tb/fws_flash_model.sv
// behavioural flash device giving status on the data lanes
`timescale 1ns/100ps
`default_nettype none
`include "fws_defs.vh"
module fws_flash_model
(
  // flash pins from the host
  input  wire logic [19:0] flash_addr,
  input  wire logic        chip_select_n,
  input  wire logic        output_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic [7:0]  data_out,
  input  wire logic        data_oe_n,
  // resolved lanes and ready line pull-down
  output wire logic [7:0]  data_in,
  output wire logic        rb_low
);
  // ============================================================
  // operation state
  logic [7:0]  mem = 8'h3c;
  logic [7:0]  pd, st, wdat;
  logic [7:0]  last = 8'h00;
  logic [19:0] waddr;
  logic        busy = 0, ers = 0, susp = 0, fail = 0, tog1 = 0, tog2 = 0;
  logic        a_e, a_s, a_f, armed = 0, prd = 0, pwr = 0;
  int          left, a_n, reads = 0;
  wire         rd_on = !chip_select_n && !output_strobe_n;
  wire         wr_on = !chip_select_n && !write_strobe_n;
  wire         in_sec = flash_addr[19:12] == waddr[19:12];
  // status byte while busy, array data otherwise and outside the
  // suspended sector
  assign st = (!busy || susp && !in_sec) ? mem :
    {ers ? susp : ~pd[7],
    tog1, fail, mem[4], mem[3] | ers,
    ers ? tog2 : mem[2], mem[1:0]};
  // released lanes show the inverse of the last value
  assign data_in = !data_oe_n ? data_out : rd_on ? st : ~last;
  assign rb_low = busy && !susp;
  // next write strobe starts this operation
  task arm(input logic e, s, f, input int n, input logic [7:0] d);
    begin
      a_e = e;
      a_s = s;
      a_f = f;
      a_n = n;
      pd = d;
      armed = 1;
    end
  endtask
  // a cycle takes effect where its strobe or select ends
  always @(rd_on or wr_on)
  begin
    if (prd && !rd_on)
    begin
      reads++;
      last = st;
      if (busy && !susp)
        tog1 = ~tog1;
      if (busy && ers && in_sec)
        tog2 = ~tog2;
      if (busy && !susp && !fail)
      begin
        left--;
        busy = left > 0; // fail never ends by itself
      end
    end
    if (pwr && !wr_on)
    begin
      wdat = data_out;
      waddr = flash_addr;
      last = data_out;
      if (busy && ers && !susp)
        armed = 0; // erase under way ignores commands
      else if (data_out == `FWS_CMD_RESET)
        busy = 0;
      else if (armed)
      begin
        busy = 1;
        ers = a_e;
        susp = a_s;
        fail = a_f;
        left = a_n; // toggle length set per scenario
        armed = 0;
      end
    end
    prd = rd_on;
    pwr = wr_on;
  end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the flash write-status host controller
`timescale 1ns/100ps
`default_nettype none
`include "fws_defs.vh"
module testbench;
  // ============================================================
  // signals
  logic        hclk, hresetn, hsel, hwrite, clk_en;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, q;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, cs_n, oe_n, we_n, d_oe_n, rb_low;
  wire  [19:0] fa;
  wire  [7:0]  dout, lanes;
  wire         ready_n = rb_low ? 1'b0 : 1'b1; // pull-up on shared line
  int          fail_count = 0, checked = 0, cyc = 0, n, r;
  initial
  begin
    hclk = 0;
    forever #50 hclk = ~hclk;
  end
  fws_host i_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .flash_addr(fa),
    .chip_select_n(cs_n), .output_strobe_n(oe_n), .write_strobe_n(we_n),
    .data_out(dout), .data_oe_n(d_oe_n), .data_in(lanes),
    .ready_busy_n_in(ready_n));
  fws_flash_model i_flash (.flash_addr(fa), .chip_select_n(cs_n),
    .output_strobe_n(oe_n), .write_strobe_n(we_n), .data_out(dout),
    .data_oe_n(d_oe_n), .data_in(lanes), .rb_low(rb_low));
  // ============================================================
  // bus, compare and closing tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checked++;
      if (got !== exp)
      begin
        fail_count++;
        $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      if (fail_count == 0 && checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // single word transfer, entered just after a rising edge
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      hsel <= 1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
    end
  endtask
  task wait_idle;
    begin
      n = 0;
      ahb(0, `FWS_REG_STATUS, 0);
      while (q[0] !== 1'b0 && n < 300)
      begin
        n++;
        ahb(0, `FWS_REG_STATUS, 0);
      end
      chk(q[0], 1'b0);
    end
  endtask
  // one write cycle on the pins starts the armed operation
  task issue(input logic e, s, f, input int left);
    begin
      i_flash.arm(e, s, f, left, 8'h80);
      ahb(1, `FWS_REG_ADDR, 32'h12345);
      ahb(1, `FWS_REG_DATA, 32'h5a);
      ahb(1, `FWS_REG_CTRL, 32'h3);
      wait_idle;
      chk(i_flash.waddr, 20'h12345);
      chk(i_flash.wdat, 8'h5a);
    end
  endtask
  // counts the lane reads one poll takes
  task poll;
    begin
      r = i_flash.reads;
      ahb(1, `FWS_REG_CTRL, 32'h5);
      wait_idle;
      r = i_flash.reads - r;
      ahb(0, `FWS_REG_STATUS, 0);
    end
  endtask
  // ============================================================
  // scenarios
  task t_regs;
    begin
      ahb(0, `FWS_REG_STATUS, 0);
      chk(q, 32'h8);
      ahb(1, `FWS_REG_STATUS, 32'h3f);
      ahb(0, `FWS_REG_STATUS, 0);
      chk(q, 32'h8);
      ahb(0, 8'h14, 0);
      chk(q, 32'h0);
    end
  endtask
  // a low enable holds a started access until it rises again
  task t_freeze;
    begin
      r = i_flash.reads;
      ahb(1, `FWS_REG_CTRL, 32'h1);
      clk_en <= 0;
      repeat (20) @(posedge hclk);
      chk(i_flash.reads - r, 0);
      clk_en <= 1;
      wait_idle;
      chk(i_flash.reads - r, 1);
      ahb(0, `FWS_REG_RDATA, 0);
      chk(q, 32'h3c);
    end
  endtask
  task t_program;
    begin
      issue(0, 0, 0, 4);
      ahb(0, `FWS_REG_STATUS, 0);
      chk(q[3], 1'b0);
      poll;
      chk(q & 32'hf, 32'ha);
      ahb(0, `FWS_REG_RDATA, 0);
      chk(q, 32'h3c);
    end
  endtask
  task t_erase;
    begin
      issue(1, 0, 0, 2);
      poll;
      chk(q & 32'hf, 32'ha);
    end
  endtask
  task t_fail;
    begin
      issue(0, 0, 1, 1);
      poll;
      chk(r, 3);
      chk(q[2], 1'b1);
      poll;
      chk(r, 3);
      ahb(1, `FWS_REG_CTRL, 32'h9);
      wait_idle;
      chk(i_flash.wdat, `FWS_CMD_RESET);
      ahb(0, `FWS_REG_STATUS, 0);
      chk(q & 32'hd, 32'h8);
    end
  endtask
  task t_suspend;
    begin
      issue(1, 1, 0, 5);
      poll;
      chk(r, 2);
      chk(q, 32'h3a);
      ahb(1, `FWS_REG_ADDR, 32'h45678);
      ahb(1, `FWS_REG_CTRL, 32'h1);
      wait_idle;
      ahb(0, `FWS_REG_RDATA, 0);
      chk(q, 32'h3c);
    end
  endtask
  // reset, then every scenario in turn
  initial
  begin
    hresetn = 0;
    hsel = 0;
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hsize = 3'b010;
    clk_en = 1;
    hwdata = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    t_regs;
    t_freeze;
    t_program;
    t_erase;
    t_fail;
    t_suspend;
    test_done;
  end
  // a hang costs a mismatch and ends the run
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      test_done;
    end
  end
endmodule
`default_nettype wire
